// >>> gpc_pin_config.sv
// Pin configuration, pull enables and alternate mode register block
`timescale 1ns/1ps
`default_nettype none

module gpc_pin_config #(
  parameter int NUM_PINS = gpc_pkg::NUM_PINS
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic shutdown_in,
  input wire logic [NUM_PINS-1:0] otp_alt_in,
  input wire gpc_pkg::gpc_reg_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_hit_out,
  input wire logic [NUM_PINS-1:0] pad_in,
  input wire logic [2:0] seq_level_in,
  input wire logic slow_clk_in,
  output logic [NUM_PINS-1:0] pad_out_out,
  output logic [NUM_PINS-1:0] pad_oe_out,
  output logic [NUM_PINS-1:0] pull_up_out,
  output logic [NUM_PINS-1:0] pull_down_out,
  output logic lpm_ctrl_out,
  output logic first_buck_dvs_out,
  output logic second_buck_dvs_out,
  output logic ref_enable_out
);

  // Register state
  gpc_pkg::gpc_pin_cfg_t cfg_ff [NUM_PINS]; // Pin configuration
  gpc_pkg::gpc_pin_cfg_t nxt_cfg [NUM_PINS];
  logic [NUM_PINS-1:0] pue_ff, nxt_pue; // Pull-up enables
  logic [NUM_PINS-1:0] pde_ff, nxt_pde; // Pull-down enables
  logic [NUM_PINS-1:0] ame_ff, nxt_ame; // Alternate enables
  logic load_ff, nxt_load; // Fuse load pending
  logic [7:0] rdata_ff, nxt_rdata; // Read data
  logic hit_ff, nxt_hit; // Read hit a register

  // Combinational pin results
  logic [NUM_PINS-1:0] mux_out, mux_oe, mux_dir, mux_func, mux_ref, alt_level;

  // Pad output registers
  logic [NUM_PINS-1:0] pad_out_ff, pad_oe_ff, pu_ff, pd_ff;
  logic lpm_ff, dvs0_ff, dvs1_ff, ref_ff;

  // One pin mux per pin
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      // Alternate output level source for pins 1 to 4
      if (gi >= 1 && gi <= 3) begin : g_seq
        assign alt_level[gi] = seq_level_in[gi-1];
      end else if (gi == 4) begin : g_clk
        assign alt_level[gi] = slow_clk_in;
      end else begin : g_none
        assign alt_level[gi] = 1'b0;
      end
      gpc_pin_mux #(.PIN(gi)) u_mux (
        .cfg_in(cfg_ff[gi]),
        .alt_en_in(ame_ff[gi]),
        .pad_in(pad_in[gi]),
        .alt_level_in(alt_level[gi]),
        .pad_out_out(mux_out[gi]),
        .pad_oe_out(mux_oe[gi]),
        .eff_dir_out(mux_dir[gi]),
        .func_level_out(mux_func[gi]),
        .ref_en_out(mux_ref[gi])
      );
    end
  endgenerate

  // Next register values: shutdown, load, bus write, bus read
  always_comb begin
    nxt_pue = pue_ff;
    nxt_pde = pde_ff;
    nxt_ame = ame_ff;
    nxt_load = 1'b0;
    nxt_rdata = rdata_ff;
    nxt_hit = hit_ff;
    for (int i = 0; i < NUM_PINS; i++) begin
      nxt_cfg[i] = cfg_ff[i];
    end
    if (shutdown_in) begin
      // Shutdown restores reset values, then reloads fuses
      nxt_pue = gpc_pkg::PULL_RST;
      nxt_pde = gpc_pkg::PULL_RST;
      nxt_ame = gpc_pkg::ALT_RST;
      nxt_load = 1'b1;
      for (int i = 0; i < NUM_PINS; i++) begin
        nxt_cfg[i] = gpc_pkg::cfg_reset(i, 1'b0);
      end
    end else if (load_ff) begin
      // Alternate enables and matching configs from fuses
      nxt_ame = otp_alt_in;
      for (int i = 0; i < NUM_PINS; i++) begin
        nxt_cfg[i] = gpc_pkg::cfg_reset(i, otp_alt_in[i]);
      end
    end else if (reg_req_in.wr) begin
      // Register write
      if (reg_req_in.addr == gpc_pkg::ADDR_PULLUP) begin
        nxt_pue = reg_req_in.wdata;
      end else if (reg_req_in.addr == gpc_pkg::ADDR_PULLDOWN) begin
        nxt_pde = reg_req_in.wdata;
      end else if (reg_req_in.addr == gpc_pkg::ADDR_ALT) begin
        nxt_ame = reg_req_in.wdata;
      end
      for (int i = 0; i < NUM_PINS; i++) begin
        if (reg_req_in.addr == gpc_pkg::ADDR_CFG_BASE + 8'(i)) begin
          nxt_cfg[i] = reg_req_in.wdata;
          // Input level is read only while the pin is an input
          if (cfg_ff[i].pin_direction) begin
            nxt_cfg[i].in_level = cfg_ff[i].in_level;
          end
        end
      end
    end
    if (reg_req_in.rd) begin
      // Register read, unmapped offsets read zero
      nxt_rdata = gpc_pkg::UNMAPPED_DATA;
      nxt_hit = 1'b0;
      if (reg_req_in.addr == gpc_pkg::ADDR_PULLUP) begin
        nxt_rdata = pue_ff;
        nxt_hit = 1'b1;
      end else if (reg_req_in.addr == gpc_pkg::ADDR_PULLDOWN) begin
        nxt_rdata = pde_ff;
        nxt_hit = 1'b1;
      end else if (reg_req_in.addr == gpc_pkg::ADDR_ALT) begin
        nxt_rdata = ame_ff;
        nxt_hit = 1'b1;
      end
      for (int i = 0; i < NUM_PINS; i++) begin
        if (reg_req_in.addr == gpc_pkg::ADDR_CFG_BASE + 8'(i)) begin
          nxt_rdata = cfg_ff[i];
          nxt_rdata[1] = mux_dir[i];
          // Live pad level shows while the pin is an input
          if (mux_dir[i]) begin
            nxt_rdata[2] = pad_in[i];
          end
          nxt_hit = 1'b1;
        end
      end
    end
  end

  // Register storage
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pue_ff <= gpc_pkg::PULL_RST;
      pde_ff <= gpc_pkg::PULL_RST;
      ame_ff <= gpc_pkg::ALT_RST;
      load_ff <= 1'b1;
      rdata_ff <= gpc_pkg::UNMAPPED_DATA;
      hit_ff <= 1'b0;
      for (int i = 0; i < NUM_PINS; i++) begin
        cfg_ff[i] <= gpc_pkg::CFG_RST_PLAIN;
      end
    end else begin
      pue_ff <= nxt_pue;
      pde_ff <= nxt_pde;
      ame_ff <= nxt_ame;
      load_ff <= nxt_load;
      rdata_ff <= nxt_rdata;
      hit_ff <= nxt_hit;
      for (int i = 0; i < NUM_PINS; i++) begin
        cfg_ff[i] <= nxt_cfg[i];
      end
    end
  end

  // Registered pad and function outputs
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pad_out_ff <= '0;
      pad_oe_ff <= '0;
      pu_ff <= '0;
      pd_ff <= '0;
      lpm_ff <= 1'b0;
      dvs0_ff <= 1'b0;
      dvs1_ff <= 1'b0;
      ref_ff <= 1'b0;
    end else begin
      pad_out_ff <= mux_out;
      pad_oe_ff <= mux_oe;
      pu_ff <= pue_ff;
      pd_ff <= pde_ff;
      lpm_ff <= mux_func[0];
      dvs0_ff <= mux_func[5];
      dvs1_ff <= mux_func[6];
      ref_ff <= mux_ref[7];
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign reg_hit_out = hit_ff;
  assign pad_out_out = pad_out_ff;
  assign pad_oe_out = pad_oe_ff;
  assign pull_up_out = pu_ff;
  assign pull_down_out = pd_ff;
  assign lpm_ctrl_out = lpm_ff;
  assign first_buck_dvs_out = dvs0_ff;
  assign second_buck_dvs_out = dvs1_ff;
  assign ref_enable_out = ref_ff;

  // Checks on the pin behaviour
  a_plain_out_drive: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (!ame_ff[2] && !cfg_ff[2].pin_direction && cfg_ff[2].drive_type_select)
    |=> (pad_oe_out[2] && pad_out_out[2] == $past(cfg_ff[2].out_level)))
    else $error("plain output pin 2 not driven");
  a_alt_out_high: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (ame_ff[1] && cfg_ff[1].drive_type_select)
    |=> (pad_oe_out[1] && pad_out_out[1] == $past(seq_level_in[0])))
    else $error("pin 1 alternate output wrong");
  a_alt_in_polarity: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ame_ff[5] |=> first_buck_dvs_out == ($past(cfg_ff[5].pin_direction) ~^ $past(pad_in[5])))
    else $error("first buck scaling input polarity wrong");
  a_open_drain_low: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (!ame_ff[3] && !cfg_ff[3].pin_direction && !cfg_ff[3].drive_type_select)
    |=> (!pad_out_out[3] && pad_oe_out[3] == !$past(cfg_ff[3].out_level)))
    else $error("open drain pin 3 wrong");
  a_input_no_drive: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (!ame_ff[0] && cfg_ff[0].pin_direction) |=> !pad_oe_out[0])
    else $error("input pin 0 driven");
  a_pull_follows: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ##1 (pull_up_out == $past(pue_ff) && pull_down_out == $past(pde_ff)))
    else $error("pull enables do not follow registers");
  a_ref_output: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ame_ff[7] |=> (ref_enable_out && !pad_oe_out[7]))
    else $error("pin 7 reference not selected");
  a_dir_forced: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (ame_ff[7] && reg_req_in.rd && reg_req_in.addr == 8'h3d) |=> !reg_rdata_out[1])
    else $error("pin 7 direction not forced to zero");
  a_second_buck_in: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ame_ff[6] |=> second_buck_dvs_out == ($past(cfg_ff[6].pin_direction) ~^ $past(pad_in[6])))
    else $error("second buck scaling input wrong");
  a_otp_load: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (load_ff && !shutdown_in) |=> ame_ff == $past(otp_alt_in))
    else $error("alternate enables not loaded from fuses");
  a_lpm_input: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !ame_ff[0] |=> !lpm_ctrl_out)
    else $error("low-power input active without alternate mode");
  a_slow_clock_out: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (ame_ff[4] && cfg_ff[4].drive_type_select) |=> pad_out_out[4] == $past(slow_clk_in))
    else $error("pin 4 slow clock not driven");
  a_shutdown_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    shutdown_in |=> (pue_ff == 8'h00 && pde_ff == 8'h00 && load_ff))
    else $error("shutdown did not restore reset values");

endmodule // gpc_pin_config
`default_nettype wire

// >>> gpc_pin_config_bench.sv
// Self-checking bench for the pin configuration block
`timescale 1ns/1ps
`default_nettype none

module gpc_pin_config_bench;
  logic clk_in = 1'b0; // Core clock
  logic reset_n_in = 1'b0; // Async reset, active low
  logic shutdown_in = 1'b0; // Global shutdown pulse
  logic [7:0] otp_alt = 8'h61; // Fuse alternate enables, pins 0/5/6
  gpc_pkg::gpc_reg_req_t req = '0; // Register request
  logic [7:0] rdata; // Read data
  logic hit; // Read hit flag
  logic [7:0] pad = 8'h00; // Pad input levels
  logic [2:0] seq = 3'b000; // Sequencer levels, pins 1..3
  logic slow_clk = 1'b0; // Slow clock level
  logic [7:0] pad_out; // Pad drive values
  logic [7:0] pad_oe; // Pad drive enables
  logic [7:0] pull_up; // Pull-up enables
  logic [7:0] pull_down; // Pull-down enables
  logic lpm; // Low-power control input
  logic dvs0; // First buck scaling input
  logic dvs1; // Second buck scaling input
  logic ref_en; // Reference buffer enable
  int error_cnt = 0; // Mismatches
  int num_checks = 0; // Comparisons

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  // Block under test
  gpc_pin_config u_gpc_pin_config (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .shutdown_in(shutdown_in),
    .otp_alt_in(otp_alt), .reg_req_in(req), .reg_rdata_out(rdata),
    .reg_hit_out(hit), .pad_in(pad), .seq_level_in(seq), .slow_clk_in(slow_clk),
    .pad_out_out(pad_out), .pad_oe_out(pad_oe), .pull_up_out(pull_up),
    .pull_down_out(pull_down), .lpm_ctrl_out(lpm), .first_buck_dvs_out(dvs0),
    .second_buck_dvs_out(dvs1), .ref_enable_out(ref_en)
  );

  // Counted compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req <= {1'b1, 1'b0, a, d};
    @(posedge clk_in);
    req <= '0;
  endtask

  // Register read, data and hit judged
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic exph);
    @(posedge clk_in);
    req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk_in);
    req <= '0;
    #1;
    chk(rdata, exp);
    chk({7'h00, hit}, {7'h00, exph});
  endtask

  // Let registered pad outputs follow
  task automatic settle();
    repeat (3) @(posedge clk_in);
    #1;
  endtask

  // Values after reset and fuse load
  task automatic t_reset();
    rd(8'h40, 8'h61, 1'b1);
    rd(8'h3e, 8'h00, 1'b1);
    rd(8'h3f, 8'h00, 1'b1);
    rd(8'h36, 8'h02, 1'b1);
    rd(8'h3a, 8'h03, 1'b1);
    rd(8'h41, 8'h00, 1'b0); // Unmapped offset
    chk(pad_oe, 8'h00);
  endtask

  // Plain pin 2 through output and input modes
  task automatic t_plain();
    logic [7:0] cfgs [4];
    logic [7:0] exps [4];
    cfgs = '{8'h09, 8'h08, 8'h00, 8'h0b};
    exps = '{8'h03, 8'h00, 8'h02, 8'h00};
    for (int i = 0; i < 4; i++) begin
      wr(8'h38, cfgs[i]);
      settle();
      // Drive value only matters while an output
      chk({6'h00, pad_oe[2], pad_out[2] & ~cfgs[i][1]}, exps[i]);
    end
  endtask

  // Pull enables map bit n to pin n
  task automatic t_pulls();
    wr(8'h3e, 8'h81);
    wr(8'h3f, 8'h24);
    settle();
    chk(pull_up, 8'h81);
    chk(pull_down, 8'h24);
    rd(8'h3f, 8'h24, 1'b1);
  endtask

  // Alternate inputs on pins 0, 5 and 6
  task automatic t_alt_in();
    @(posedge clk_in);
    pad <= 8'h61;
    settle();
    chk({5'h00, lpm, dvs0, dvs1}, 8'h07);
    wr(8'h3c, 8'h01);
    settle();
    chk({5'h00, lpm, dvs0, dvs1}, 8'h06);
    chk(pad_oe & 8'h61, 8'h00);
    @(posedge clk_in);
    pad <= 8'h00;
    settle();
    chk({5'h00, lpm, dvs0, dvs1}, 8'h01);
  endtask

  // Alternate outputs on pins 1-4 and reference on pin 7
  task automatic t_alt_out();
    wr(8'h37, 8'h01);
    wr(8'h38, 8'h01);
    wr(8'h39, 8'h01);
    wr(8'h3a, 8'h01);
    wr(8'h3d, 8'h03);
    wr(8'h3e, 8'h01);
    wr(8'h40, 8'h9e);
    seq <= 3'b101;
    slow_clk <= 1'b1;
    settle();
    chk(pad_oe & 8'h1e, 8'h1e);
    chk(pad_out & 8'h1e, 8'h1a);
    chk({7'h00, ref_en}, 8'h01);
    rd(8'h3d, 8'h01, 1'b1);
    rd(8'h3a, 8'h01, 1'b1);
    @(posedge clk_in);
    slow_clk <= 1'b0;
    settle();
    chk(pad_out & 8'h10, 8'h00);
  endtask

  // Shutdown restores reset values and reloads fuses
  task automatic t_shutdown();
    wr(8'h3e, 8'h7f);
    @(posedge clk_in);
    shutdown_in <= 1'b1;
    @(posedge clk_in);
    shutdown_in <= 1'b0;
    settle();
    rd(8'h3e, 8'h00, 1'b1);
    rd(8'h40, 8'h61, 1'b1);
    rd(8'h38, 8'h02, 1'b1);
    chk({7'h00, ref_en}, 8'h00);
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("Checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_reset();
    t_plain();
    t_pulls();
    t_alt_in();
    t_alt_out();
    t_shutdown();
    stop_test();
  end

  // Watchdog, far beyond the expected run of about 110 cycles
  initial begin
    #50000;
    error_cnt++;
    stop_test();
  end
endmodule // gpc_pin_config_bench

`default_nettype wire

// >>> gpc_pin_mux.sv
// Per-pin pad control and alternate function select
`timescale 1ns/1ps
`default_nettype none

module gpc_pin_mux #(
  parameter int PIN = 0
) (
  input wire gpc_pkg::gpc_pin_cfg_t cfg_in,
  input wire logic alt_en_in,
  input wire logic pad_in,
  input wire logic alt_level_in,
  output logic pad_out_out,
  output logic pad_oe_out,
  output logic eff_dir_out,
  output logic func_level_out,
  output logic ref_en_out
);

  logic drives; // Pad driver in use
  logic level; // Level the driver shows

  // Pad driver, direction and alternate function decode
  always_comb begin
    drives = 1'b0;
    level = 1'b0;
    if (!alt_en_in) begin
      // Plain pin, direction field rules
      drives = !cfg_in.pin_direction;
      level = cfg_in.out_level;
    end else if (gpc_pkg::is_alt_out_pin(PIN)) begin
      // Active-high alternate output whatever the direction field
      drives = 1'b1;
      level = alt_level_in;
    end
    if (drives && cfg_in.drive_type_select) begin
      // Push-pull driver
      pad_oe_out = 1'b1;
      pad_out_out = level;
    end else if (drives) begin
      // Open drain: only pulls low
      pad_oe_out = !level;
      pad_out_out = 1'b0;
    end else begin
      // Input or reference: drive type ignored
      pad_oe_out = 1'b0;
      pad_out_out = 1'b0;
    end
    // Direction seen inside, cleared for pins 4 and 7 in alternate mode
    eff_dir_out = (alt_en_in && (PIN == 4 || PIN == 7)) ? 1'b0 : cfg_in.pin_direction;
    // Alternate input with selectable polarity
    if (alt_en_in && gpc_pkg::is_alt_in_pin(PIN)) begin
      func_level_out = cfg_in.pin_direction ? pad_in : !pad_in;
    end else begin
      func_level_out = 1'b0;
    end
    ref_en_out = alt_en_in && (PIN == 7);
  end

endmodule // gpc_pin_mux
`default_nettype wire

// >>> gpc_pkg.sv
// Package with the constants, types and helpers of the pin configuration block
package gpc_pkg;

  // Number of pins handled
  localparam int NUM_PINS = 8;

  // Register offsets on the management bus
  localparam logic [7:0] ADDR_CFG_BASE = 8'h36;
  localparam logic [7:0] ADDR_PULLUP = 8'h3e;
  localparam logic [7:0] ADDR_PULLDOWN = 8'h3f;
  localparam logic [7:0] ADDR_ALT = 8'h40;

  // Pin configuration values after reset
  localparam logic [7:0] CFG_RST_PLAIN = 8'h02;
  localparam logic [7:0] CFG_RST_PIN4_PLAIN = 8'h03;
  localparam logic [7:0] CFG_RST_ALT_IN = 8'h02;
  localparam logic [7:0] CFG_RST_ALT_OUT = 8'h00;
  localparam logic [7:0] CFG_RST_PIN4_ALT = 8'h01;

  // Pull and alternate enables after reset, before the fuse load
  localparam logic [7:0] PULL_RST = 8'h00;
  localparam logic [7:0] ALT_RST = 8'h00;

  // Value returned for an unmapped read
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // Pin configuration register layout, bit 7 first
  typedef struct packed {
    logic [1:0] input_debounce_sel; // Debounce time code
    logic [1:0] edge_irq_select; // Edge interrupt code
    logic out_level; // Output drive level
    logic in_level; // Input level, read only as input
    logic pin_direction; // 0 output, 1 input
    logic drive_type_select; // 0 open drain, 1 push pull
  } gpc_pin_cfg_t;

  // One register access from the serial engine
  typedef struct packed {
    logic wr; // Write strobe, one cycle
    logic rd; // Read strobe, one cycle
    logic [7:0] addr; // Register offset
    logic [7:0] wdata; // Write data
  } gpc_reg_req_t;

  // Pins whose alternate function drives the pad
  function automatic logic is_alt_out_pin(input int pin);
    return (pin >= 1) && (pin <= 4);
  endfunction

  // Pins whose alternate function is a polarity-selected input
  function automatic logic is_alt_in_pin(input int pin);
    return (pin == 0) || (pin == 5) || (pin == 6);
  endfunction

  // Reset value of one pin configuration register
  function automatic logic [7:0] cfg_reset(input int pin, input logic alt);
    logic [7:0] val;
    val = CFG_RST_PLAIN;
    if (!alt) begin
      val = (pin == 4) ? CFG_RST_PIN4_PLAIN : CFG_RST_PLAIN;
    end else if (pin == 4) begin
      val = CFG_RST_PIN4_ALT;
    end else if (is_alt_in_pin(pin)) begin
      val = CFG_RST_ALT_IN;
    end else begin
      val = CFG_RST_ALT_OUT;
    end
    return val;
  endfunction

endpackage
